// >>> core/cla_pkg.sv
// Constants, encodings and helpers for the compact low-register ALU decoder.
// Assumes a single core clock; no software-visible registers.
package cla_pkg;

   // Controller states and recognised instruction formats
   typedef enum logic [1:0] {CLA_IDLE, CLA_EXEC, CLA_MULW} cla_state_t;
   typedef enum logic [2:0] {
      FMT_SHIFT, FMT_ADDSUB, FMT_IMM8, FMT_PAIR, FMT_HI, FMT_OTHER
   } cla_fmt_t;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [1:0] MUL_EXTRA = 2'h3;

   // Register field width, flag reset value and full shift amount
   localparam int REG_W = 3;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] SHIFT_FULL = 8'h20;

   // Format match values on the top bits
   localparam logic [2:0] FMT1_TOP = 3'h0;
   localparam logic [4:0] FMT2_TOP = 5'h03;
   localparam logic [2:0] FMT3_TOP = 3'h1;
   localparam logic [5:0] FMT4_TOP = 6'h10;
   localparam logic [5:0] FMT5_TOP = 6'h11;

   // Field positions
   localparam int DST_LO = 0;
   localparam int SRC_LO = 3;
   localparam int RN_LO = 6;
   localparam int IMM5_LO = 6;
   localparam int OP1_LO = 11;
   localparam int OP2_SUB = 9;
   localparam int OP2_IMM = 10;
   localparam int DST3_LO = 8;
   localparam int OP4_LO = 6;
   localparam int HI2_BIT = 6;
   localparam int HI1_BIT = 7;
   localparam int HOP_LO = 8;

   // Shift kinds; formats 1 use the first three directly
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;

   // Immediate-format operations
   localparam logic [1:0] IMM_MOVE = 2'h0;
   localparam logic [1:0] IMM_COMPARE = 2'h1;
   localparam logic [1:0] IMM_ADD = 2'h2;
   localparam logic [1:0] IMM_SUB = 2'h3;

   // Register-pair operations
   localparam logic [3:0] PR_AND = 4'h0;
   localparam logic [3:0] PR_XOR = 4'h1;
   localparam logic [3:0] PR_SHL = 4'h2;
   localparam logic [3:0] PR_SHR = 4'h3;
   localparam logic [3:0] PR_SAR = 4'h4;
   localparam logic [3:0] PR_ADD_CARRY = 4'h5;
   localparam logic [3:0] PR_SUB_CARRY = 4'h6;
   localparam logic [3:0] PR_ROTATE = 4'h7;
   localparam logic [3:0] PR_AND_TEST = 4'h8;
   localparam logic [3:0] PR_NEGATE = 4'h9;
   localparam logic [3:0] PR_COMPARE = 4'ha;
   localparam logic [3:0] PR_COMPARE_NEG = 4'hb;
   localparam logic [3:0] PR_OR = 4'hc;
   localparam logic [3:0] PR_MULTIPLY = 4'hd;
   localparam logic [3:0] PR_BIT_CLEAR = 4'he;
   localparam logic [3:0] PR_MOVE_INV = 4'hf;

   function automatic cla_fmt_t cla_decode(input logic [15:0] ir);
      cla_fmt_t f;
      f = FMT_OTHER;
      if (ir[15:11] == FMT2_TOP)
         f = FMT_ADDSUB;
      else if (ir[15:13] == FMT1_TOP)
         f = FMT_SHIFT;
      else if (ir[15:13] == FMT3_TOP)
         f = FMT_IMM8;
      else if (ir[15:10] == FMT4_TOP)
         f = FMT_PAIR;
      else if (ir[15:10] == FMT5_TOP)
         f = FMT_HI;
      return f;
   endfunction

   // Returns {overflow, carry, sum}
   function automatic logic [33:0] cla_add(input logic [31:0] a,
                                           input logic [31:0] b,
                                           input logic cin);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      return {(a[31] == b[31]) && (s[31] != a[31]), s};
   endfunction

endpackage

// >>> core/cla_shifter.sv
// Barrel shifter with carry out for immediate and register shifts.
// Purely combinational; amount zero leaves value and carry untouched.
`timescale 1ns/100ps
`default_nettype none
module cla_shifter (
   // Operand
   input wire logic [31:0] val,
   input wire logic [7:0] amt,
   input wire logic [1:0] kind,
   input wire logic c_in,
   // Result
   output logic [31:0] res,
   output logic c_out
);
   import cla_pkg::*;

   always_comb begin
      logic [63:0] wide;
      wide = '0;
      res = val;
      c_out = c_in;
      if (amt != 8'h00) begin
         unique case (kind)
            SH_LSL: begin
               wide = {32'h0, val} << amt;
               res = wide[31:0];
               c_out = wide[32];
            end
            SH_LSR: begin
               wide = {val, 32'h0} >> amt;
               res = wide[63:32];
               c_out = wide[31];
            end
            SH_ASR: begin
               // Large amounts saturate to all sign bits
               wide = 64'($signed({val, 32'h0}) >>> amt);
               res = wide[63:32];
               c_out = wide[31];
            end
            SH_ROR: begin
               wide = {val, val} >> amt[4:0];
               res = wide[31:0];
               c_out = wide[31];
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> core/cla_regfile.sv
// Low register bank, eight words, one write and two registered reads.
// Reads sample the address at the clock edge; a write lands the same edge.
`timescale 1ns/100ps
`default_nettype none
module cla_regfile (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Read ports
   input wire logic [2:0] rd_a_addr,
   input wire logic [2:0] rd_b_addr,
   output logic [31:0] rd_a_data,
   output logic [31:0] rd_b_data,
   // Write port
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [31:0] wr_data
);
   logic [31:0] mem [8];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_a_data <= '0;
         rd_b_data <= '0;
      end else begin
         rd_a_data <= mem[rd_a_addr];
         rd_b_data <= mem[rd_b_addr];
      end
   end
endmodule
`default_nettype wire

// >>> core/cla_lo_alu_decode.sv
// Decoder and executor for the shift, add/sub, immediate and register-pair
// formats of the compact instruction set, plus field split of the high
// register format. Fed one instruction at a time by the fetch stage.
`timescale 1ns/100ps
`default_nettype none
module cla_lo_alu_decode (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Instruction issue
   input wire logic instr_valid,
   input wire logic [15:0] instr_data,
   output logic instr_ready,
   // Register preload from the core
   input wire logic ld_en,
   input wire logic [cla_pkg::REG_W-1:0] ld_addr,
   input wire logic [31:0] ld_data,
   // Completion
   output logic op_done,
   output logic op_unhandled,
   output logic res_wr,
   output logic [cla_pkg::REG_W-1:0] res_dst,
   output logic [31:0] res_data,
   // Status flags
   output logic flag_n,
   output logic flag_z,
   output logic flag_c,
   output logic flag_v,
   // High register format fields
   output logic hi_fmt,
   output logic [3:0] hi_dst,
   output logic [3:0] hi_src,
   output logic [1:0] hi_op
);
   import cla_pkg::*;

   typedef struct packed {
      cla_state_t st;
      logic [15:0] ir;
      logic [1:0] cnt;
      logic [3:0] nzcv;
      logic done;
      logic unh;
      logic wr;
      logic [2:0] dst;
      logic [31:0] data;
      logic hi_fmt;
      logic [3:0] hi_dst;
      logic [3:0] hi_src;
      logic [1:0] hi_op;
   } cla_ctl_t;

   cla_ctl_t s_ff;
   cla_ctl_t nxt_s;
   logic [15:0] cur_ir;
   cla_fmt_t cur_fmt;
   cla_fmt_t ex_fmt;
   logic [2:0] rd_a_addr;
   logic [2:0] rd_b_addr;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] sh_res;
   logic sh_c;
   logic [7:0] sh_amt;
   logic [1:0] sh_kind;
   logic [4:0] imm5;
   logic [31:0] ex_res;
   logic [3:0] ex_nzcv;
   logic [2:0] ex_dst;
   logic ex_wr;
   logic ex_mul;
   logic ex_exec;
   logic commit;
   logic rf_we;

   // Before issue the read ports look at the incoming word, after it at
   // the held word, so operands stay put through a multiply
   assign cur_ir = (s_ff.st == CLA_IDLE) ? instr_data : s_ff.ir;
   assign cur_fmt = cla_decode(cur_ir);
   assign ex_fmt = cla_decode(s_ff.ir);
   assign ex_exec = (ex_fmt != FMT_HI) && (ex_fmt != FMT_OTHER);

   always_comb begin
      // Operand A is the shifted/added source in formats one and two and
      // the destination otherwise; only 3-bit fields ever reach the bank
      if (cur_fmt == FMT_SHIFT || cur_fmt == FMT_ADDSUB)
         rd_a_addr = cur_ir[SRC_LO +: 3];
      else if (cur_fmt == FMT_IMM8)
         rd_a_addr = cur_ir[DST3_LO +: 3];
      else
         rd_a_addr = cur_ir[DST_LO +: 3];
      if (cur_fmt == FMT_ADDSUB)
         rd_b_addr = cur_ir[RN_LO +: 3];
      else
         rd_b_addr = cur_ir[SRC_LO +: 3];
   end

   cla_regfile u_bank (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .rd_a_addr(rd_a_addr),
      .rd_b_addr(rd_b_addr),
      .rd_a_data(a),
      .rd_b_data(b),
      .wr_en(rf_we | ld_en),
      .wr_addr(rf_we ? ex_dst : ld_addr),
      .wr_data(rf_we ? ex_res : ld_data)
   );

   // Immediate shifts of zero mean 32 for the right shifts
   assign imm5 = s_ff.ir[IMM5_LO +: 5];
   always_comb begin
      if (ex_fmt == FMT_SHIFT) begin
         sh_kind = s_ff.ir[OP1_LO +: 2];
         if (imm5 == 5'h00 && sh_kind != SH_LSL)
            sh_amt = SHIFT_FULL;
         else
            sh_amt = {3'h0, imm5};
      end else begin
         sh_kind = {s_ff.ir[OP4_LO + 2], s_ff.ir[OP4_LO]};
         sh_amt = b[7:0];
      end
   end

   cla_shifter u_shift (
      .val(a),
      .amt(sh_amt),
      .kind(sh_kind),
      .c_in(s_ff.nzcv[1]),
      .res(sh_res),
      .c_out(sh_c)
   );

   always_comb begin
      logic [33:0] sum;
      logic [63:0] prod;
      logic [31:0] opnd;
      logic c_new;
      logic v_new;
      logic arith;
      sum = '0;
      prod = a * b;
      opnd = '0;
      c_new = s_ff.nzcv[1];
      v_new = s_ff.nzcv[0];
      arith = 1'b0;
      ex_res = '0;
      ex_wr = 1'b0;
      ex_mul = 1'b0;
      ex_dst = s_ff.ir[DST_LO +: 3];
      unique case (ex_fmt)
         FMT_SHIFT: begin
            ex_res = sh_res;
            c_new = sh_c;
            ex_wr = 1'b1;
         end
         FMT_ADDSUB: begin
            opnd = s_ff.ir[OP2_IMM] ? {29'h0, s_ff.ir[RN_LO +: 3]} : b;
            sum = s_ff.ir[OP2_SUB] ? cla_add(a, ~opnd, 1'b1)
                                   : cla_add(a, opnd, 1'b0);
            arith = 1'b1;
            ex_wr = 1'b1;
         end
         FMT_IMM8: begin
            ex_dst = s_ff.ir[DST3_LO +: 3];
            opnd = {24'h0, s_ff.ir[7:0]};
            unique case (s_ff.ir[OP1_LO +: 2])
               IMM_MOVE: ex_res = opnd;
               IMM_COMPARE: sum = cla_add(a, ~opnd, 1'b1);
               IMM_ADD: sum = cla_add(a, opnd, 1'b0);
               IMM_SUB: sum = cla_add(a, ~opnd, 1'b1);
            endcase
            ex_wr = s_ff.ir[OP1_LO +: 2] != IMM_COMPARE;
            arith = s_ff.ir[OP1_LO +: 2] != IMM_MOVE;
         end
         FMT_PAIR: begin
            ex_wr = 1'b1;
            arith = s_ff.ir[OP4_LO +: 4] inside {PR_ADD_CARRY,
               PR_SUB_CARRY, PR_COMPARE, PR_COMPARE_NEG, PR_NEGATE};
            unique case (s_ff.ir[OP4_LO +: 4])
               PR_AND: ex_res = a & b;
               PR_XOR: ex_res = a ^ b;
               PR_OR: ex_res = a | b;
               PR_BIT_CLEAR: ex_res = a & ~b;
               PR_MOVE_INV: ex_res = ~b;
               PR_SHL, PR_SHR, PR_SAR, PR_ROTATE: begin
                  ex_res = sh_res;
                  c_new = sh_c;
               end
               PR_ADD_CARRY: sum = cla_add(a, b, s_ff.nzcv[1]);
               PR_SUB_CARRY: sum = cla_add(a, ~b, s_ff.nzcv[1]);
               PR_AND_TEST: begin
                  ex_res = a & b;
                  ex_wr = 1'b0;
               end
               PR_COMPARE: begin
                  sum = cla_add(a, ~b, 1'b1);
                  ex_wr = 1'b0;
               end
               PR_COMPARE_NEG: begin
                  sum = cla_add(a, b, 1'b0);
                  ex_wr = 1'b0;
               end
               PR_NEGATE: sum = cla_add(32'h0, ~b, 1'b1);
               PR_MULTIPLY: begin
                  ex_res = prod[31:0];
                  ex_mul = 1'b1;
               end
            endcase
         end
         FMT_HI, FMT_OTHER: begin
         end
      endcase
      // Arithmetic ops report through the adder; shifts take C from the shifter, other ops keep C and V.
      // Selected by opcode, not by a non-zero sum, so 0 + 0 clears C and V
      if (arith) begin
         ex_res = sum[31:0];
         c_new = sum[32];
         v_new = sum[33];
      end
      ex_nzcv = {ex_res[31], ex_res == 32'h0, c_new, v_new};
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      nxt_s.unh = 1'b0;
      nxt_s.wr = 1'b0;
      commit = 1'b0;
      unique case (s_ff.st)
         CLA_IDLE: begin
            if (instr_valid) begin
               nxt_s.ir = instr_data;
               nxt_s.st = CLA_EXEC;
               nxt_s.hi_fmt = cur_fmt == FMT_HI;
               nxt_s.hi_dst = {instr_data[HI1_BIT],
                               instr_data[DST_LO +: 3]};
               nxt_s.hi_src = {instr_data[HI2_BIT],
                               instr_data[SRC_LO +: 3]};
               nxt_s.hi_op = instr_data[HOP_LO +: 2];
            end
         end
         CLA_EXEC: begin
            // Multiply holds extra cycles like its full-width form
            if (ex_mul) begin
               nxt_s.st = CLA_MULW;
               nxt_s.cnt = MUL_EXTRA - 2'h1;
            end else begin
               commit = 1'b1;
            end
         end
         CLA_MULW: begin
            if (s_ff.cnt == 2'h0)
               commit = 1'b1;
            else
               nxt_s.cnt = s_ff.cnt - 2'h1;
         end
         default: nxt_s.st = CLA_IDLE;
      endcase
      if (commit) begin
         nxt_s.st = CLA_IDLE;
         if (ex_exec) begin
            nxt_s.done = 1'b1;
            nxt_s.wr = ex_wr;
            nxt_s.dst = ex_dst;
            nxt_s.data = ex_res;
            nxt_s.nzcv = ex_nzcv;
         end else begin
            nxt_s.unh = 1'b1;
         end
      end
   end

   // A preload colliding with a committed register write is dropped; the core owns ordering
   assign rf_we = commit && ex_exec && ex_wr;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   assign instr_ready = s_ff.st == CLA_IDLE;
   assign op_done = s_ff.done;
   assign op_unhandled = s_ff.unh;
   assign res_wr = s_ff.wr;
   assign res_dst = s_ff.dst;
   assign res_data = s_ff.data;
   assign {flag_n, flag_z, flag_c, flag_v} = s_ff.nzcv;
   assign hi_fmt = s_ff.hi_fmt;
   assign hi_dst = s_ff.hi_dst;
   assign hi_src = s_ff.hi_src;
   assign hi_op = s_ff.hi_op;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_take;
      instr_valid && instr_ready;
   endsequence

   sequence s_alu_done;
      ##1 !op_done ##1 op_done;
   endsequence

   property p_move_byte;
      s_take ##0 instr_data[15:11] == 5'h04 |-> ##2 op_done && res_wr &&
         res_data == {24'h0, $past(instr_data[7:0], 2)} &&
         flag_z == ($past(instr_data[7:0], 2) == 8'h00);
   endproperty
   a_move_byte: assert property (p_move_byte)
      else $error("byte move result or zero flag wrong");

   property p_compare_byte;
      s_take ##0 instr_data[15:11] == 5'h05 |-> ##2 op_done && !res_wr;
   endproperty
   a_compare_byte: assert property (p_compare_byte)
      else $error("immediate compare wrote a register");

   property p_flags_only;
      s_take ##0 (instr_data[15:6] == 10'h108 ||
                  instr_data[15:6] == 10'h10a ||
                  instr_data[15:6] == 10'h10b) |-> ##2 op_done && !res_wr;
   endproperty
   a_flags_only: assert property (p_flags_only)
      else $error("test or compare wrote a register");

   property p_mul_time;
      s_take ##0 instr_data[15:6] == 10'h10d |->
         ##1 (!op_done)[*4] ##1 (op_done && res_wr);
   endproperty
   a_mul_time: assert property (p_mul_time)
      else $error("multiply did not finish on its fifth cycle");

   property p_alu_time;
      s_take ##0 instr_data[15:14] == 2'h0 ||
                 instr_data[15:10] == 6'h10 && instr_data[9:6] != 4'hd
         |-> s_alu_done;
   endproperty
   a_alu_time: assert property (p_alu_time)
      else $error("single-cycle operation late or early");

   property p_hi_fields;
      s_take |=> hi_dst == {$past(instr_data[7]), $past(instr_data[2:0])}
         && hi_src == {$past(instr_data[6]), $past(instr_data[5:3])}
         && hi_op == $past(instr_data[9:8]);
   endproperty
   a_hi_fields: assert property (p_hi_fields)
      else $error("high format fields split wrongly");

   property p_flags_at_done;
      $changed(s_ff.nzcv) |-> op_done;
   endproperty
   a_flags_at_done: assert property (p_flags_at_done)
      else $error("flags moved without a completion");

   property p_dest_field;
      s_take ##0 instr_data[15:13] == 3'h1 |->
         ##2 res_dst == $past(instr_data[10:8], 2);
   endproperty
   a_dest_field: assert property (p_dest_field)
      else $error("immediate format destination wrong");

   property p_hi_unhandled;
      s_take ##0 instr_data[15:10] == 6'h11 |->
         ##2 op_unhandled && !op_done && hi_fmt;
   endproperty
   a_hi_unhandled: assert property (p_hi_unhandled)
      else $error("high format not reported as unhandled");
endmodule
`default_nettype wire

// >>> bench/cla_fetch_model.sv
// Stand-in for the fetch stage and the register preload path of the core.
// Assumes every task is entered at a falling edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module cla_fetch_model (
   // Clock
   input wire logic clk_sys,
   // Issue
   input wire logic instr_ready,
   output logic instr_valid,
   output logic [15:0] instr_data,
   // Preload
   output logic ld_en,
   output logic [2:0] ld_addr,
   output logic [31:0] ld_data
);
   initial begin
      instr_valid = 1'b0;
      instr_data = 16'hffff;
      ld_en = 1'b0;
      ld_addr = 3'h0;
      ld_data = 32'h0;
   end

   // Holds the word until an edge with ready high, or until eight tries fail, then lets it go
   task automatic issue(input logic [15:0] w, output bit ok);
      ok = 1'b0;
      instr_valid = 1'b1;
      instr_data = w;
      for (int k = 0; k < 8; k++) begin
         if (instr_ready === 1'b1) begin
            ok = 1'b1;
            break;
         end
         @(negedge clk_sys);
      end
      if (ok)
         @(posedge clk_sys);
      @(negedge clk_sys);
      // Released bus shows the inverse so a stale sample cannot match
      instr_valid = 1'b0;
      instr_data = ~w;
   endtask

   task automatic preload(input logic [2:0] a, input logic [31:0] d);
      ld_en = 1'b1;
      ld_addr = a;
      ld_data = d;
      @(negedge clk_sys);
      ld_en = 1'b0;
      ld_data = ~d;
      @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// >>> bench/cla_lo_alu_decode_tb.sv
// Self-checking bench for the compact low-register decoder.
// Assumes the fetch model file is compiled first; one core clock.
`timescale 1ns/100ps
`default_nettype none
module cla_lo_alu_decode_tb;
   import cla_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_valid, instr_ready, ld_en, op_done, op_unhandled, res_wr;
   logic [15:0] instr_data;
   logic [2:0] ld_addr, res_dst;
   logic [31:0] ld_data, res_data;
   logic flag_n, flag_z, flag_c, flag_v, hi_fmt;
   logic [3:0] hi_dst, hi_src;
   logic [1:0] hi_op;
   int err_total = 0;
   int checks = 0;
   logic [31:0] rf [8];
   logic [3:0] fl = 4'h0;

   always #4 clk_sys = ~clk_sys;

   cla_fetch_model cla_fetch_model_i (.clk_sys(clk_sys),
      .instr_ready(instr_ready), .instr_valid(instr_valid),
      .instr_data(instr_data), .ld_en(ld_en), .ld_addr(ld_addr),
      .ld_data(ld_data));

   cla_lo_alu_decode cla_lo_alu_decode_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_data(instr_data), .instr_ready(instr_ready), .ld_en(ld_en),
      .ld_addr(ld_addr), .ld_data(ld_data), .op_done(op_done),
      .op_unhandled(op_unhandled), .res_wr(res_wr), .res_dst(res_dst),
      .res_data(res_data), .flag_n(flag_n), .flag_z(flag_z),
      .flag_c(flag_c), .flag_v(flag_v), .hi_fmt(hi_fmt), .hi_dst(hi_dst),
      .hi_src(hi_src), .hi_op(hi_op));

   task automatic chk(input string nm, input logic [31:0] exp, got);
      checks++;
      if (exp !== got) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Returns {carry, value}; amount zero keeps both
   function automatic logic [32:0] shf(input logic [31:0] v,
      input logic [7:0] n, input logic [1:0] k, input logic ci);
      logic [63:0] t;
      logic [32:0] s;
      shf = {ci, v};
      if (n != 8'h0)
         case (k)
            SH_LSL: begin
               t = {32'h0, v} << n;
               shf = t[32:0];
            end
            SH_LSR: begin
               t = {v, 32'h0} >> n;
               shf = {t[31], t[63:32]};
            end
            SH_ASR: begin
               s = $signed({v, 1'b0}) >>> ((n > SHIFT_FULL) ? SHIFT_FULL : n);
               shf = {s[0], s[32:1]};
            end
            default: begin
               t = {v, v} >> n[4:0];
               shf = {t[31], t[31:0]};
            end
         endcase
   endfunction

   function automatic logic [33:0] addv(input logic [31:0] a, b,
      input logic ci);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b} + {32'h0, ci};
      addv = {(a[31] == b[31]) && (s[31] != a[31]), s};
   endfunction

   task automatic load(input logic [2:0] a, input logic [31:0] d);
      cla_fetch_model_i.preload(a, d);
      rf[a] = d;
   endtask

   task automatic run_op(input logic [15:0] w);
      logic [31:0] a, b, r;
      logic [33:0] x;
      logic [3:0] op, nf;
      logic [2:0] d;
      logic wr, ar, sh;
      bit ok;
      int k;
      a = rf[w[5:3]];
      d = w[2:0];
      op = w[9:6];
      wr = 1'b1;
      ar = 1'b0;
      sh = 1'b0;
      if (w[15:11] == FMT2_TOP) begin
         b = w[OP2_IMM] ? {29'h0, w[8:6]} : rf[w[8:6]];
         x = addv(a, w[OP2_SUB] ? ~b : b, w[OP2_SUB]);
         ar = 1'b1;
      end else if (w[15:13] == FMT1_TOP) begin
         b = {27'h0, w[10:6]};
         if (b == 32'h0 && w[12:11] != SH_LSL)
            b = {24'h0, SHIFT_FULL};
         x = {1'b0, shf(a, b[7:0], w[12:11], fl[1])};
         sh = 1'b1;
      end else if (w[15:13] == FMT3_TOP) begin
         d = w[10:8];
         a = rf[d];
         b = {24'h0, w[7:0]};
         ar = w[12:11] != IMM_MOVE;
         wr = w[12:11] != IMM_COMPARE;
         x = (w[12:11] == IMM_MOVE) ? {2'h0, b} :
             (w[12:11] == IMM_ADD) ? addv(a, b, 1'b0) : addv(a, ~b, 1'b1);
      end else begin
         a = rf[d];
         b = rf[w[5:3]];
         ar = op inside {PR_ADD_CARRY, PR_SUB_CARRY, PR_NEGATE, PR_COMPARE,
                         PR_COMPARE_NEG};
         wr = !(op inside {PR_AND_TEST, PR_COMPARE, PR_COMPARE_NEG});
         sh = op inside {PR_SHL, PR_SHR, PR_SAR, PR_ROTATE};
         case (op)
            PR_AND, PR_AND_TEST: x = {2'h0, a & b};
            PR_XOR: x = {2'h0, a ^ b};
            PR_ADD_CARRY: x = addv(a, b, fl[1]);
            PR_SUB_CARRY: x = addv(a, ~b, fl[1]);
            PR_NEGATE: x = addv(32'h0, ~b, 1'b1);
            PR_COMPARE: x = addv(a, ~b, 1'b1);
            PR_COMPARE_NEG: x = addv(a, b, 1'b0);
            PR_OR: x = {2'h0, a | b};
            PR_MULTIPLY: x = {2'h0, a * b};
            PR_BIT_CLEAR: x = {2'h0, a & ~b};
            PR_MOVE_INV: x = {2'h0, ~b};
            default: x = {1'b0, shf(a, b[7:0], (op == PR_ROTATE) ? SH_ROR :
                                    op[1:0] - 2'h2, fl[1])};
         endcase
      end
      r = x[31:0];
      nf = {r[31], r == 32'h0, (ar || sh) ? x[32] : fl[1],
            ar ? x[33] : fl[0]};
      cla_fetch_model_i.issue(w, ok);
      chk("taken", 1, ok);
      chk("ready", 0, instr_ready);
      for (k = 2; k < 9; k++) begin
         @(negedge clk_sys);
         if (op_done === 1'b1)
            break;
      end
      chk("latency", (op == PR_MULTIPLY && !sh && !ar && wr &&
          w[15:10] == FMT4_TOP) ? 5 : 2, k);
      if (k == 9)
         end_of_test();
      chk("res_wr", wr, res_wr);
      chk("res_dst", d, res_dst);
      chk("res_data", r, res_data);
      chk("flags", nf, {flag_n, flag_z, flag_c, flag_v});
      chk("hi_fmt", 0, hi_fmt);
      fl = nf;
      if (wr)
         rf[d] = r;
   endtask

   task automatic run_other(input logic [15:0] w);
      bit ok;
      cla_fetch_model_i.issue(w, ok);
      chk("taken", 1, ok);
      chk("hi_fmt", w[15:10] == FMT5_TOP, hi_fmt);
      chk("hi_dst", {w[7], w[2:0]}, hi_dst);
      chk("hi_src", {w[6], w[5:3]}, hi_src);
      chk("hi_op", w[9:8], hi_op);
      @(negedge clk_sys);
      chk("unhandled", 1, op_unhandled);
      chk("op_done", 0, op_done);
      chk("flags", fl, {flag_n, flag_z, flag_c, flag_v});
   endtask

   task automatic t_reset();
      chk("ready", 1, instr_ready);
      chk("flags", 0, {flag_n, flag_z, flag_c, flag_v});
      chk("done", 0, {op_done, op_unhandled, res_wr});
   endtask

   task automatic t_shift();
      logic [4:0] amt [3] = '{5'h00, 5'h01, 5'h1b};
      for (int i = 0; i < 8; i++)
         load(i[2:0], 32'h8000_00f1 ^ (32'h1357_9bdf << i));
      for (int op = 0; op < 3; op++)
         for (int j = 0; j < 3; j++)
            run_op({3'h0, op[1:0], amt[j], 3'h5, 3'h2});
   endtask

   task automatic t_addsub();
      load(3'h3, 32'h7fff_ffff);
      load(3'h4, 32'h0000_0001);
      for (int s = 0; s < 4; s++)
         run_op({5'h03, s[0], s[1], 3'h4, 3'h3, 3'h0});
      load(3'h0, 32'h0);
      run_op({3'h1, IMM_COMPARE, 3'h0, 8'h00});
      run_op({5'h03, 1'b0, 1'b0, 3'h0, 3'h0, 3'h1});
   endtask

   task automatic t_imm();
      for (int op = 0; op < 4; op++) begin
         run_op({3'h1, op[1:0], 3'h6, 8'h80});
         run_op({3'h1, op[1:0], 3'h2, 8'hff});
      end
   endtask

   task automatic t_pair();
      logic [5:0] pr [4] = '{6'h0a, 6'h1c, 6'h35, 6'h3f};
      load(3'h1, 32'h0000_0020);
      load(3'h3, 32'h0000_0004);
      load(3'h6, 32'h0000_0000);
      load(3'h7, 32'hffff_ff21);
      for (int p = 0; p < 4; p++)
         for (int op = 0; op < 16; op++)
            run_op({6'h10, op[3:0], pr[p]});
   endtask

   task automatic t_other();
      run_other(16'h46b5);
      run_other(16'h457a);
      run_other(16'hf000);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_shift();
      t_addsub();
      t_imm();
      t_pair();
      t_other();
      end_of_test();
   end
endmodule
`default_nettype wire
